// file: bench/twowire_slave_register_port_tb.sv
// Purpose: Self-checking bench for the two-wire slave
// Assumes: Timeout shortened to 200 cycles
// Notes:   Read data is the pointer xor 5a
`timescale 1ns/1ps
module twowire_slave_register_port_tb;
  import twsrp_pkg::*;
  localparam int TO = 200;
  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  logic        scl, sda_low, sda_oe, sda_out, busy, timeout_en;
  logic        wr_valid, wr_ready = 1'b1;
  logic [1:0]  sel = 2'h1;
  logic [7:0]  wr_index, wr_data, rd_index, rd_data = 8'h00;
  logic [15:0] q[$];
  int          err_total = 0, checked = 0, cyc = 0;
  wire sda = !sda_low && !(sda_oe && !sda_out);
  always #20 mclk = ~mclk;
  twsrp_master i_twsrp_master (.mclk(mclk), .sda_bus(sda),
    .scl(scl), .sda_low(sda_low));
  twsrp_top #(.TIMEOUT_CYC(TO)) i_twsrp_top (.mclk(mclk),
    .nrst(nrst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .slave_addr_select_pin(sel),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_index(wr_index),
    .wr_data(wr_data), .rd_index(rd_index), .rd_data(rd_data),
    .busy(busy), .timeout_en(timeout_en));
  // Register contents seen by the read port
  always @(negedge mclk) rd_data <= rd_index ^ 8'h5a;
  // Stream words taken and the hang limit
  always @(posedge mclk)
  begin
    if (wr_valid === 1'b1 && wr_ready) q.push_back({wr_index, wr_data});
    cyc++;
    if (cyc == 30000)
    begin
      err_total++;
      final_report();
    end
  end
  task automatic chk(input string n, input logic [15:0] s, e);
    checked++;
    if (s !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", n, e, s);
      err_total++;
    end
  endtask
  function automatic logic [7:0] ab(input logic r);
    return {TWSRP_ADDR_HI, sel, r};
  endfunction
  task automatic xfer_w(input logic [7:0] p, input int n,
                        input logic [7:0] d, output int a);
    logic k;
    i_twsrp_master.start();
    i_twsrp_master.wbyte(ab(1'b0), k);
    a = (k === 1'b1);
    i_twsrp_master.wbyte(p, k);
    a += (k === 1'b1);
    for (int i = 0; i < n; i++)
    begin
      i_twsrp_master.wbyte(8'(d + i), k);
      a += (k === 1'b1);
    end
    i_twsrp_master.stop();
  endtask
  task automatic rd(input int n, input logic [7:0] p);
    logic k;
    logic [7:0] b;
    i_twsrp_master.start();
    i_twsrp_master.wbyte(ab(1'b1), k);
    chk("rd ack", k, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      i_twsrp_master.rbyte(i == n - 1, b);
      chk("rd data", b, 8'(p + i) ^ 8'h5a);
    end
    i_twsrp_master.stop();
  endtask
  task automatic t_write();
    int a;
    q.delete();
    xfer_w(8'h10, 2, 8'ha1, a);
    chk("wr acks", a, 4);
    repeat (4) @(negedge mclk);
    chk("wr count", q.size(), 2);
    chk("wr w0", q[0], 16'h10a1);
    chk("wr w1", q[1], 16'h11a2);
  endtask
  task automatic t_fill();
    int a;
    q.delete();
    wr_ready = 1'b0;
    xfer_w(8'h30, 9, 8'hc0, a);
    chk("full acks", a, 10);
    wr_ready = 1'b1;
    repeat (20) @(negedge mclk);
    chk("drain count", q.size(), 8);
    for (int i = 0; i < 8; i++)
      chk("drain w", q[i], {8'(8'h30 + i), 8'(8'hc0 + i)});
  endtask
  task automatic t_read();
    int a;
    logic k;
    xfer_w(8'h50, 0, 8'h00, a);
    chk("ptr acks", a, 2);
    rd(2, 8'h50);
    i_twsrp_master.start();
    i_twsrp_master.wbyte(ab(1'b0), k);
    i_twsrp_master.wbyte(8'h40, k);
    rd(3, 8'h40);
  endtask
  task automatic t_addr();
    int a;
    logic k;
    q.delete();
    for (int s = 0; s < 4; s++)
    begin
      sel = 2'(s);
      i_twsrp_master.start();
      i_twsrp_master.wbyte({TWSRP_ADDR_HI, sel ^ 2'h1, 1'b0}, k);
      chk("miss ack", k, 1'b0);
      i_twsrp_master.wbyte(8'h00, k);
      chk("miss byte", k, 1'b0);
      i_twsrp_master.stop();
      xfer_w(8'h60, 0, 8'h00, a);
      chk("hit acks", a, 2);
    end
    chk("miss words", q.size(), 0);
    sel = 2'h1;
  endtask
  task automatic t_tout();
    int a;
    logic k;
    xfer_w(TWSRP_CFG_REG, 1, 8'h80, a);
    chk("to off", timeout_en, 1'b0);
    i_twsrp_master.start();
    i_twsrp_master.wbyte(ab(1'b0), k);
    repeat (TO + 40) @(negedge mclk);
    chk("no reset", busy, 1'b1);
    i_twsrp_master.stop();
    xfer_w(TWSRP_CFG_REG, 1, 8'h00, a);
    chk("to on", timeout_en, 1'b1);
    i_twsrp_master.start();
    i_twsrp_master.wbyte(ab(1'b0), k);
    chk("busy", busy, 1'b1);
    repeat (TO + 40) @(negedge mclk);
    chk("low stall", busy, 1'b0);
    i_twsrp_master.stop();
    i_twsrp_master.start();
    i_twsrp_master.wbyte(ab(1'b0), k);
    repeat (2) @(negedge mclk);
    i_twsrp_master.scl = 1'b1;
    repeat (8) @(negedge mclk);
    chk("high busy", busy, 1'b1);
    repeat (TO + 32) @(negedge mclk);
    chk("high stall", busy, 1'b0);
    i_twsrp_master.scl = 1'b0;
    repeat (2) @(negedge mclk);
    i_twsrp_master.stop();
  endtask
  task automatic final_report();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Reset, then the scenarios in turn
  initial
  begin
    repeat (20) @(negedge mclk);
    nrst = 1'b1;
    repeat (4) @(negedge mclk);
    chk("rst en", timeout_en, 1'b1);
    t_write();
    t_fill();
    t_read();
    t_addr();
    t_tout();
    final_report();
  end
endmodule

// file: bench/twsrp_master.sv
// Purpose: Two-wire bus master model
// Assumes: Tasks are entered just after a falling mclk edge
// Notes:   SCL bit time is 8 mclk (320 ns); SCL still between frames
`timescale 1ns/1ps
module twsrp_master
(
  // Clock and bus
  input  wire logic mclk,
  input  wire logic sda_bus,
  output logic      scl,
  output logic      sda_low
);
  // Idle bus is high on both lines
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // One bit, data set while SCL low and held over SCL high
  task automatic bit_x(input logic b, output logic s);
    sda_low = !b;
    repeat (2) @(negedge mclk);
    scl = 1'b1;
    repeat (2) @(negedge mclk);
    s = sda_bus;
    repeat (2) @(negedge mclk);
    scl = 1'b0;
    repeat (2) @(negedge mclk);
  endtask
  // Start or repeated start
  task automatic start();
    sda_low = 1'b0;
    repeat (2) @(negedge mclk);
    scl = 1'b1;
    repeat (2) @(negedge mclk);
    sda_low = 1'b1;
    repeat (2) @(negedge mclk);
    scl = 1'b0;
    repeat (2) @(negedge mclk);
  endtask
  // Stop, then bus left idle
  task automatic stop();
    sda_low = 1'b1;
    repeat (2) @(negedge mclk);
    scl = 1'b1;
    repeat (2) @(negedge mclk);
    sda_low = 1'b0;
    repeat (4) @(negedge mclk);
  endtask
  // Byte out MSB first, ninth pulse reads the acknowledge
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(b[i], s);
    bit_x(1'b1, s);
    ack = !s;
  endtask
  // Byte in, master acknowledges unless last
  task automatic rbyte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, b[i]);
    bit_x(last, s);
  endtask
endmodule

// file: bench/twsrp_top_sva.sv
// Purpose: Assertions on the two-wire slave pins and write stream
// Assumes: Pins are driven on falling mclk edges
// Notes:   Timeout bound allows slack for the synchroniser
`timescale 1ns/1ps
module twsrp_sva
#(
  parameter int TIMEOUT_CYC = 200
)
(
  // Watched ports
  input wire logic       mclk,
  input wire logic       nrst,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       wr_valid,
  input wire logic       wr_ready,
  input wire logic [7:0] wr_index,
  input wire logic [7:0] wr_data,
  input wire logic       busy,
  input wire logic       timeout_en
);
  logic        scl_r;
  logic [15:0] stall_r;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // Previous SCL level
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst) scl_r <= 1'b1;
    else scl_r <= scl_in;
  // Cycles without an SCL edge during a transfer
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst) stall_r <= '0;
    else if (!busy || scl_in != scl_r) stall_r <= '0;
    else stall_r <= stall_r + 16'h1;
  sequence s_stop;
    scl_in && $rose(sda_in);
  endsequence
  sequence s_held;
    sda_oe [*5];
  endsequence
  property p_sda_out; sda_out == 1'b0; endproperty
  a_sda_out: assert property (p_sda_out)
    else $error("sda_out driven high");
  property p_oe_chg; $changed(sda_oe) |-> !scl_in; endproperty
  a_oe_chg: assert property (p_oe_chg)
    else $error("sda_oe moved while scl high");
  property p_oe_hold; $rose(sda_oe) |-> s_held; endproperty
  a_oe_hold: assert property (p_oe_hold)
    else $error("sda low too short");
  property p_idle_oe; !busy |-> !sda_oe; endproperty
  a_idle_oe: assert property (p_idle_oe)
    else $error("sda pulled while not addressed");
  property p_stop; s_stop |-> ##[1:8] !busy; endproperty
  a_stop: assert property (p_stop)
    else $error("busy after stop");
  property p_wr_hold;
    wr_valid && !wr_ready |=>
      wr_valid && $stable(wr_index) && $stable(wr_data);
  endproperty
  a_wr_hold: assert property (p_wr_hold)
    else $error("stream word changed before taken");
  property p_tout;
    busy && timeout_en |-> stall_r <= TIMEOUT_CYC + 8;
  endproperty
  a_tout: assert property (p_tout)
    else $error("stalled transfer not reset");
  property p_cfg; $changed(timeout_en) |-> busy; endproperty
  a_cfg: assert property (p_cfg)
    else $error("timeout enable moved outside write");
endmodule
bind twsrp_top twsrp_sva #(.TIMEOUT_CYC(TIMEOUT_CYC)) i_twsrp_sva
(
  .mclk(mclk), .nrst(nrst), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .wr_valid(wr_valid),
  .wr_ready(wr_ready), .wr_index(wr_index), .wr_data(wr_data),
  .busy(busy), .timeout_en(timeout_en)
);

// file: logic/twsrp_fifo.sv
// Purpose: Small valid/ready FIFO with registered read data
// Assumes: Single clock, write and read may coincide
// Notes:   Occupancy is the pointer gap plus the registered head word
`timescale 1ns/1ps
module twsrp_fifo
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
)
(
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             nrst,
  // Filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wp_r;
  logic [AW:0]      rp_r;
  logic [AW:0]      cnt;
  logic             push;
  logic             pop;

  // Occupancy counts the head register too, so DEPTH words at most
  assign cnt      = wp_r - rp_r + (AW+1)'(out_valid);
  assign in_ready = (cnt != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign push     = in_valid & in_ready;
  assign pop      = out_valid & out_ready;

  // Storage
  always_ff @(posedge mclk)
  begin
    if (push)
      mem[wp_r[AW-1:0]] <= in_data;
  end

  // Write pointer
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      wp_r <= '0;
    else if (push)
      wp_r <= wp_r + (AW+1)'(1);
  end

  // Read pointer and registered head word
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      rp_r      <= '0;
      out_valid <= 1'b0;
      out_data  <= '0;
    end
    else if (!out_valid || out_ready)
    begin
      if (rp_r != wp_r)
      begin
        out_data  <= mem[rp_r[AW-1:0]];
        out_valid <= 1'b1;
        rp_r      <= rp_r + (AW+1)'(1);
      end
      else
        out_valid <= 1'b0;
    end
  end

endmodule

// file: logic/twsrp_pkg.sv
// Purpose: Shared constants for the two-wire slave register port
// Assumes: Core clock mclk at 25 MHz
// Notes:   Timeout counts derive from the time in microseconds
package twsrp_pkg;

  // ----------------------------------------------------------------------
  // Addressing
  // ----------------------------------------------------------------------
  localparam logic [4:0] TWSRP_ADDR_HI     = 5'h13;  // 1,0,0,1,1
  localparam logic [7:0] TWSRP_CFG_REG     = 8'h27;  // Configuration register
  localparam int         TWSRP_CFG_TO_BIT  = 7;      // Timeout disable bit
  localparam logic [7:0] TWSRP_CFG_RST     = 8'h00;  // Timeout enabled
  localparam logic [7:0] TWSRP_PTR_RST     = 8'h00;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int TWSRP_CLK_KHZ     = 25000;
  localparam int TWSRP_TIMEOUT_US  = 31000;
  localparam int TWSRP_TIMEOUT_CYC =
    (TWSRP_TIMEOUT_US / 1000) * TWSRP_CLK_KHZ;
  localparam int TWSRP_TO_W        = 20;

  // ----------------------------------------------------------------------
  // Buffering
  // ----------------------------------------------------------------------
  localparam int TWSRP_FIFO_DEPTH  = 8;
  localparam int TWSRP_FIFO_WIDTH  = 16;       // Register index + data

  typedef enum logic [2:0] {
    TWSRP_IDLE,
    TWSRP_ADDR,
    TWSRP_ACK,
    TWSRP_WRX,
    TWSRP_RTX,
    TWSRP_RACK,
    TWSRP_IGN
  } twsrp_state_e;

endpackage

// file: logic/twsrp_top.sv
// Purpose: Two-wire slave with register pointer and bus timeout
// Assumes: SCL and SDA are asynchronous pins, sampled by mclk
// Notes:   Written bytes leave through a FIFO; reads use rd_data
`timescale 1ns/1ps
module twsrp_top
#(
  parameter int TIMEOUT_CYC = twsrp_pkg::TWSRP_TIMEOUT_CYC
)
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       nrst,
  // Two-wire pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // Address select decoded level pair
  input  wire logic [1:0] slave_addr_select_pin,
  // Register write stream
  output logic            wr_valid,
  input  wire logic       wr_ready,
  output logic [7:0]      wr_index,
  output logic [7:0]      wr_data,
  // Register read port
  output logic [7:0]      rd_index,
  input  wire logic [7:0] rd_data,
  // Status
  output logic            busy,
  output logic            timeout_en
);
  import twsrp_pkg::*;

  // ----------------------------------------------------------------------
  // Pin synchronisers and edges
  // ----------------------------------------------------------------------
  logic [1:0] scl_s_r;
  logic [1:0] sda_s_r;
  logic       scl_d_r;
  logic       sda_d_r;
  logic [1:0] sel_m_r;
  logic [1:0] sel_r;

  // Two flops on each pin, then one delayed copy for edges
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      scl_s_r <= 2'h3;
      sda_s_r <= 2'h3;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      sel_m_r <= 2'h0;
      sel_r   <= 2'h0;
    end
    else
    begin
      scl_s_r <= {scl_s_r[0], scl_in};
      sda_s_r <= {sda_s_r[0], sda_in};
      scl_d_r <= scl_s_r[1];
      sda_d_r <= sda_s_r[1];
      sel_m_r <= slave_addr_select_pin;  // Select pin is asynchronous
      sel_r   <= sel_m_r;
    end
  end

  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;

  assign scl      = scl_s_r[1];
  assign sda      = sda_s_r[1];
  assign scl_rise = scl & ~scl_d_r;
  assign scl_fall = ~scl & scl_d_r;
  assign start_ev = scl & scl_d_r & sda_d_r & ~sda;
  assign stop_ev  = scl & scl_d_r & ~sda_d_r & sda;

  // ----------------------------------------------------------------------
  // Byte engine
  // ----------------------------------------------------------------------
  twsrp_state_e state_r;
  logic [7:0]   sh_r;
  logic [3:0]   bit_r;
  logic         rnw_r;
  logic         first_r;
  logic         ack_drv_r;
  logic [7:0]   ptr_r;
  logic [7:0]   cfg_r;
  logic         to_fire;
  logic         fifo_in_ready;
  logic         push_r;
  logic [15:0]  push_word_r;
  logic [6:0]   my_addr;

  // Own address from fixed bits and select pin
  assign my_addr = {TWSRP_ADDR_HI, sel_r};

  // Pointer increment shared by reads and writes
  function automatic logic [7:0] ptr_inc(input logic [7:0] p);
    ptr_inc = p + 8'h01;
  endfunction

  // Main receive and transmit sequencer
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r   <= TWSRP_IDLE;
      sh_r      <= 8'h00;
      bit_r     <= 4'h0;
      rnw_r     <= 1'b0;
      first_r   <= 1'b0;
      ack_drv_r <= 1'b0;
      ptr_r     <= TWSRP_PTR_RST;
      push_r    <= 1'b0;
      push_word_r <= 16'h0000;
    end
    else
    begin
      push_r <= 1'b0;
      if (to_fire)
      begin
        state_r   <= TWSRP_IDLE;
        ack_drv_r <= 1'b0;
      end
      else if (start_ev)
      begin
        state_r   <= TWSRP_ADDR;
        bit_r     <= 4'h0;
        ack_drv_r <= 1'b0;
      end
      else if (stop_ev)
      begin
        state_r   <= TWSRP_IDLE;
        ack_drv_r <= 1'b0;
      end
      else
      begin
        case (state_r)
          TWSRP_ADDR, TWSRP_WRX:
          begin
            if (scl_rise)
            begin
              sh_r  <= {sh_r[6:0], sda};
              bit_r <= bit_r + 4'h1;
            end
            else if (scl_fall && bit_r == 4'h8)
            begin
              bit_r <= 4'h0;
              if (state_r == TWSRP_ADDR)
              begin
                if (sh_r[7:1] == my_addr)
                begin
                  rnw_r     <= sh_r[0];
                  first_r   <= 1'b1;
                  ack_drv_r <= 1'b1;
                  state_r   <= TWSRP_ACK;
                end
                else
                  state_r <= TWSRP_IGN;
              end
              else if (first_r)
              begin
                ptr_r     <= sh_r;
                first_r   <= 1'b0;
                ack_drv_r <= 1'b1;
                state_r   <= TWSRP_ACK;
              end
              else if (fifo_in_ready)
              begin
                push_r      <= 1'b1;
                push_word_r <= {ptr_r, sh_r};
                ptr_r       <= ptr_inc(ptr_r);
                ack_drv_r   <= 1'b1;
                state_r     <= TWSRP_ACK;
              end
              else
                state_r <= TWSRP_IGN;  // Full buffer: no ack
            end
          end
          TWSRP_ACK:
          begin
            // Ack held low across the ninth high phase
            if (scl_fall)
            begin
              ack_drv_r <= 1'b0;
              if (rnw_r)
              begin
                sh_r      <= rd_data;
                ptr_r     <= ptr_inc(ptr_r);
                ack_drv_r <= ~rd_data[7];
                state_r   <= TWSRP_RTX;
              end
              else
                state_r <= TWSRP_WRX;
            end
          end
          TWSRP_RTX:
          begin
            // Shift changes only on SCL falling edges
            if (scl_fall)
            begin
              if (bit_r == 4'h7)
              begin
                bit_r     <= 4'h0;
                ack_drv_r <= 1'b0;
                state_r   <= TWSRP_RACK;
              end
              else
              begin
                bit_r     <= bit_r + 4'h1;
                sh_r      <= {sh_r[6:0], 1'b0};
                ack_drv_r <= ~sh_r[6];
              end
            end
          end
          TWSRP_RACK:
          begin
            if (scl_rise && sda)
              state_r <= TWSRP_IGN;  // Master nack ends the read
            else if (scl_fall)
            begin
              sh_r      <= rd_data;
              ptr_r     <= ptr_inc(ptr_r);
              ack_drv_r <= ~rd_data[7];
              state_r   <= TWSRP_RTX;
            end
          end
          default:
            ack_drv_r <= 1'b0;
        endcase
      end
    end
  end

  assign rd_index = ptr_r;
  assign busy     = (state_r != TWSRP_IDLE) && (state_r != TWSRP_IGN);

  // Open-drain drive: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe  = ack_drv_r;

  // ----------------------------------------------------------------------
  // Configuration register copy and timeout
  // ----------------------------------------------------------------------
  logic                  cfg_hit;
  logic [TWSRP_TO_W-1:0] to_cnt_r;

  assign cfg_hit = push_r && push_word_r[15:8] == TWSRP_CFG_REG;

  // Shadow of the configuration register written over the bus
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      cfg_r <= TWSRP_CFG_RST;
    else if (cfg_hit)
      cfg_r <= push_word_r[7:0];
  end

  assign timeout_en = ~cfg_r[TWSRP_CFG_TO_BIT];

  // Stall counter: restarts on START and on any SCL edge
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      to_cnt_r <= '0;
    else if (start_ev || scl_rise || scl_fall || !busy)
      to_cnt_r <= '0;
    else if (to_cnt_r != TWSRP_TO_W'(TIMEOUT_CYC))
      to_cnt_r <= to_cnt_r + TWSRP_TO_W'(1);
  end

  assign to_fire = timeout_en && busy
                && (to_cnt_r == TWSRP_TO_W'(TIMEOUT_CYC));

  // ----------------------------------------------------------------------
  // Write stream buffer
  // ----------------------------------------------------------------------
  logic [15:0] fifo_out;

  twsrp_fifo #(
    .WIDTH (TWSRP_FIFO_WIDTH),
    .DEPTH (TWSRP_FIFO_DEPTH)
  ) i_twsrp_fifo (
    .mclk      (mclk),
    .nrst      (nrst),
    .in_valid  (push_r),
    .in_ready  (fifo_in_ready),
    .in_data   (push_word_r),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  (fifo_out)
  );

  assign wr_index = fifo_out[15:8];
  assign wr_data  = fifo_out[7:0];

endmodule
